// [src/mfc_consts.svh]
// Register offsets, field positions, reset values and counts for the modem event and cipher block.
`ifndef MFC_CONSTS_SVH
`define MFC_CONSTS_SVH

// Register offsets within the modem register module.
`define MFC_OFS_FLAGS        5'h00
`define MFC_OFS_CIPHER       5'h01

// Reset values of both registers.
`define MFC_FLAGS_RST        16'h0000
`define MFC_CIPHER_RST       8'h1c

// Field positions of the flag and enable register.
`define MFC_NUM_FLAGS        8
`define MFC_FLAG_PHY_TX      0
`define MFC_FLAG_MGR_TX      1
`define MFC_FLAG_PHY_RX      2
`define MFC_FLAG_MGR_RX      3
`define MFC_FLAG_CIPHER      4
`define MFC_FLAG_CARRIER     5
`define MFC_FLAG_FRAME       6
`define MFC_FLAG_OVF         7
`define MFC_EN_LSB           8
`define MFC_EN_MSB           15

// Field positions of the cipher control register.
`define MFC_BIT_START        0
`define MFC_BIT_MODE         1
`define MFC_OP_LSB           2
`define MFC_OP_MSB           3
`define MFC_BIT_DONE         4
`define MFC_OP_BIT_CRC       0
`define MFC_OP_BIT_DES       1

// Operation select encodings.
`define MFC_OP_OFF           2'b00
`define MFC_OP_CRC_ONLY      2'b01
`define MFC_OP_DES_ONLY      2'b10
`define MFC_OP_BOTH          2'b11

// Reset values of the cipher control fields.
`define MFC_START_RST        1'b0
`define MFC_MODE_RST         1'b0
`define MFC_OP_RST           2'b11
`define MFC_DONE_RST         1'b1

// CRC accumulator seed, buffer geometry and cipher control read padding.
`define MFC_CRC_SEED         32'hffffffff
`define MFC_WORDS_PER_BLOCK  4
`define MFC_CIPHER_PAD_W     11

`endif

// [src/mfc_pkg.sv]
// Types shared by the modem event and cipher control block.
package mfc_pkg;

	// Operation select field: CRC enable in bit 0, cipher enable in bit 1.
	typedef logic [1:0] mfc_op_t;

	// Cipher sequencer states.
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_BLOCK,
		ST_CRC_LO,
		ST_CRC_HI
	} mfc_state_t;

endpackage : mfc_pkg

// [src/mfc_sticky_bit.sv]
// One sticky event flag that hardware sets and software writes.
`timescale 1ns/1ns
`default_nettype none
module mfc_sticky_bit #(
	parameter logic RST_VAL = 1'b0
) (
	input  wire logic clk,
	input  wire logic srst,
	input  wire logic set_evt,
	input  wire logic sw_wr,
	input  wire logic sw_val,
	output logic      q
);
	logic q_reg;   // Stored flag.
	logic q_next;  // Next flag value.

	// A hardware set wins over a software write in the same cycle.
	always_comb begin
		q_next = set_evt | (sw_wr ? sw_val : q_reg);
	end

	// Register the flag.
	always_ff @(posedge clk) begin
		if (srst) begin
			q_reg <= RST_VAL;
		end else begin
			q_reg <= q_next;
		end
	end

	assign q = q_reg;
endmodule : mfc_sticky_bit
`default_nettype wire

// [src/mfc_top.sv]
// Frame event flags, interrupt enables and cipher control sequencer for the modem.
//
// Operation
// - PHY transmit flag sets on last bit out.
// - Three transmit triggers each launch a transmission.
// - Manager transmit flag only for output-start frames.
// - PHY receive flag sets on last decoded bit.
// - Manager receive flag sets on stored frame.
// - Cipher done flag after CRC store cycles, or right after the data without CRC.
// - Carrier sense flag sets on carrier detect.
// - Frame detect flag sets on valid frame.
// - Overflow enabled: set flag, flush decoder frame.
// - Overflow disabled: no automatic flush happens.
// - Upper byte enables gate the interrupt from flags below them.
// - Flag register resets zero, fully read/write.
// - Cipher control resets 1Ch, bit 4 read-only.
// - Start processes blocks from address, writing back in cipher modes.
// - CRC appended right after processed data.
// - Start reloads CRC accumulator with all ones.
// - Hardware clears start once operation begins.
// - Direction bit: zero decrypts, one encrypts.
// - Operation field selects off, CRC, cipher, both.
// - Operation off makes start do nothing.
// - CRC-only mode never writes data back.
// - Cipher-only mode skips the CRC write.
// - Done bit low while running, else high.
// - Block count is whole 64-bit blocks.
`timescale 1ns/1ns
`default_nettype none
`include "mfc_consts.svh"
module mfc_top #(
	parameter int ADDR_W = 16,
	parameter int CNT_W  = 16
) (
	input  wire logic                CORE_CLK,
	input  wire logic                SRST,
	input  wire logic [4:0]          SFR_ADDR,
	input  wire logic                SFR_WR_EN,
	input  wire logic                SFR_RD_EN,
	input  wire logic [15:0]         SFR_WDATA,
	output logic      [15:0]         SFR_RDATA,
	input  wire logic                PHY_TX_LAST_BIT,
	input  wire logic                MGR_TX_LAST_BYTE,
	input  wire logic                PHY_RX_LAST_BIT,
	input  wire logic                MGR_RX_LAST_BYTE,
	input  wire logic                CARRIER_DETECT,
	input  wire logic                FRAME_VALID,
	input  wire logic                OUTPUT_FRAME_GO,
	input  wire logic                RETRANSMIT_GO,
	input  wire logic                ACKNOWLEDGE_GO,
	input  wire logic                NEW_FRAME_INCOMING,
	input  wire logic                DECODER_HOLDS_DATA,
	input  wire logic [ADDR_W-1:0]   CIPHER_START_ADDRESS,
	input  wire logic [CNT_W-1:0]    CIPHER_BLOCK_COUNT,
	input  wire logic                ENGINE_BLOCK_DONE,
	output logic                     IRQ,
	output logic                     TX_LAUNCH,
	output logic                     DECODER_FLUSH,
	output mfc_pkg::mfc_op_t         ENGINE_OP,
	output logic                     ENGINE_ENCRYPT,
	output logic                     ENGINE_BLOCK_REQ,
	output logic                     ENGINE_WRITE_BACK,
	output logic      [ADDR_W-1:0]   ENGINE_BLOCK_ADDR,
	output logic                     CRC_SEED_LOAD,
	output logic      [31:0]         CRC_SEED,
	output logic                     CRC_STORE,
	output logic                     CIPHER_DONE
);
	import mfc_pkg::*;

	// Refuse widths that cannot hold a block address or count.
	generate
		if (ADDR_W < 3 || ADDR_W > 16 || CNT_W < 1 || CNT_W > 16) begin : g_bad_width
			$error("mfc_top: ADDR_W must be 3..16 and CNT_W 1..16");
		end
	endgenerate

	localparam logic [ADDR_W-1:0] BLOCK_STEP = ADDR_W'(`MFC_WORDS_PER_BLOCK); // Words per block.
	localparam logic [ADDR_W-1:0] ADDR_ONE   = ADDR_W'(1);                    // One word.
	localparam logic [CNT_W-1:0]  CNT_ONE    = CNT_W'(1);                     // One block left.
	localparam logic [CNT_W-1:0]  CNT_ZERO   = '0;                            // No blocks.

	// Register access strobes.
	logic wr_flags;   // Write to the flag and enable register.
	logic wr_cipher;  // Write to the cipher control register.

	// Sticky flag bank.
	logic [`MFC_NUM_FLAGS-1:0] flag_set;  // Hardware set events.
	logic [`MFC_NUM_FLAGS-1:0] flag_q;    // Current flags.

	// Control state and its next values.
	logic [`MFC_NUM_FLAGS-1:0] en_reg, en_next;            // Enable byte.
	logic                      start_reg, start_next;      // Start request.
	logic                      mode_reg, mode_next;        // Direction.
	mfc_op_t                   op_reg, op_next;            // Operation select.
	mfc_state_t                state_reg, state_next;      // Sequencer state.
	mfc_op_t                   run_op_reg, run_op_next;    // Operation latched at launch.
	logic                      run_enc_reg, run_enc_next;  // Direction latched at launch.
	logic [CNT_W-1:0]          left_reg, left_next;        // Blocks still to process.
	logic [ADDR_W-1:0]         addr_reg, addr_next;        // Current word address.
	logic                      req_reg, req_next;          // Block request pulse.
	logic                      seed_reg, seed_next;        // CRC seed load pulse.
	logic                      store_reg, store_next;      // CRC store strobe.
	logic                      done_reg, done_next;        // Engine idle status.
	logic                      launch_reg, launch_next;    // Transmit launch pulse.
	logic                      from_go_reg, from_go_next;  // Frame came from output start.
	logic                      flush_reg, flush_next;      // Decoder flush pulse.
	logic                      irq_reg, irq_next;          // Interrupt request.
	logic                      wb_reg, wb_next;            // Write-back level to the engine.
	logic [15:0]               rdata_reg, rdata_next;      // Read data.
	logic [31:0]               crc_seed_reg;               // Seed value presented to engine.
	logic                      cipher_fin;                 // Operation finishes now.
	logic                      go_tail;                    // Data phase is over: last block done, or a start with a block count of zero.
	logic                      overflow;                   // Overflow detected now.

	// Decode writes; offsets are compared in an if chain style by equality.
	always_comb begin
		wr_flags  = 1'b0;
		wr_cipher = 1'b0;
		if (SFR_WR_EN && SFR_ADDR == `MFC_OFS_FLAGS) begin
			wr_flags = 1'b1;
		end else if (SFR_WR_EN && SFR_ADDR == `MFC_OFS_CIPHER) begin
			wr_cipher = 1'b1;
		end
	end

	// Overflow is only looked for while its enable is set.
	assign overflow = NEW_FRAME_INCOMING & DECODER_HOLDS_DATA & en_reg[`MFC_NUM_FLAGS-1];

	// Hardware set events for each flag.
	always_comb begin
		flag_set                    = '0;
		flag_set[`MFC_FLAG_PHY_TX]  = PHY_TX_LAST_BIT;
		flag_set[`MFC_FLAG_MGR_TX]  = MGR_TX_LAST_BYTE & from_go_reg;
		flag_set[`MFC_FLAG_PHY_RX]  = PHY_RX_LAST_BIT;
		flag_set[`MFC_FLAG_MGR_RX]  = MGR_RX_LAST_BYTE;
		flag_set[`MFC_FLAG_CIPHER]  = cipher_fin;
		flag_set[`MFC_FLAG_CARRIER] = CARRIER_DETECT;
		flag_set[`MFC_FLAG_FRAME]   = FRAME_VALID;
		flag_set[`MFC_FLAG_OVF]     = overflow;
	end

	// One sticky bit per flag; a set beats a software write of zero.
	genvar gi;
	generate
		for (gi = 0; gi < `MFC_NUM_FLAGS; gi++) begin : g_flag
			mfc_sticky_bit #(
				.RST_VAL (1'(`MFC_FLAGS_RST >> gi))
			) u_flag (
				.clk     (CORE_CLK),
				.srst    (SRST),
				.set_evt (flag_set[gi]),
				.sw_wr   (wr_flags),
				.sw_val  (SFR_WDATA[gi]),
				.q       (flag_q[gi])
			);
		end
	endgenerate

	// Next values of all control state.
	always_comb begin
		en_next      = en_reg;
		start_next   = start_reg;
		mode_next    = mode_reg;
		op_next      = op_reg;
		state_next   = state_reg;
		run_op_next  = run_op_reg;
		run_enc_next = run_enc_reg;
		left_next    = left_reg;
		addr_next    = addr_reg;
		req_next     = 1'b0;
		seed_next    = 1'b0;
		store_next   = 1'b0;
		cipher_fin   = 1'b0;
		go_tail      = 1'b0;
		rdata_next   = rdata_reg;
		// Any of the three triggers launches a transmission.
		launch_next = OUTPUT_FRAME_GO | RETRANSMIT_GO | ACKNOWLEDGE_GO;
		// Remember whether the frame in flight moves buffer data.
		if (OUTPUT_FRAME_GO) begin
			from_go_next = 1'b1;
		end else if (RETRANSMIT_GO || ACKNOWLEDGE_GO) begin
			from_go_next = 1'b0;
		end else if (MGR_TX_LAST_BYTE) begin
			from_go_next = 1'b0;
		end else begin
			from_go_next = from_go_reg;
		end
		flush_next = overflow;
		// Cipher sequencer.
		case (state_reg)
			ST_IDLE: begin
				if (start_reg) begin
					start_next = 1'b0;
					if (op_reg != `MFC_OP_OFF) begin
						seed_next    = 1'b1;
						run_op_next  = op_reg;
						run_enc_next = mode_reg;
						left_next    = CIPHER_BLOCK_COUNT;
						addr_next    = CIPHER_START_ADDRESS;
						if (CIPHER_BLOCK_COUNT == CNT_ZERO) begin
							go_tail = 1'b1;
						end else begin
							req_next   = 1'b1;
							state_next = ST_BLOCK;
						end
					end
				end
			end
			ST_BLOCK: begin
				if (ENGINE_BLOCK_DONE) begin
					left_next = left_reg - CNT_ONE;
					addr_next = addr_reg + BLOCK_STEP;
					if (left_reg == CNT_ONE) begin
						go_tail = 1'b1;
					end else begin
						req_next = 1'b1;
					end
				end
			end
			ST_CRC_LO: begin
				store_next = 1'b1;
				addr_next  = addr_reg + ADDR_ONE;
				state_next = ST_CRC_HI;
			end
			ST_CRC_HI: begin
				cipher_fin = 1'b1;
				state_next = ST_IDLE;
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
		// After the data: store the CRC in two cycles, or finish at once.
		if (go_tail) begin
			if (run_op_next[`MFC_OP_BIT_CRC]) begin
				store_next = 1'b1;
				state_next = ST_CRC_LO;
			end else begin
				cipher_fin = 1'b1;
				state_next = ST_IDLE;
			end
		end

		// Software writes follow the hardware clear so a fresh start survives.
		if (wr_flags) begin
			en_next = SFR_WDATA[`MFC_EN_MSB:`MFC_EN_LSB];
		end
		if (wr_cipher) begin
			start_next = SFR_WDATA[`MFC_BIT_START];
			mode_next  = SFR_WDATA[`MFC_BIT_MODE];
			op_next    = SFR_WDATA[`MFC_OP_MSB:`MFC_OP_LSB];
		end

		// The done bit follows the sequencer state.
		done_next = (state_next == ST_IDLE);
		wb_next   = run_op_next[`MFC_OP_BIT_DES] & ~done_next;

		// Interrupt: any flag with its matching enable.
		irq_next = |(flag_q & en_reg);

		// Register read; unmapped offsets read zero.
		if (SFR_RD_EN) begin
			if (SFR_ADDR == `MFC_OFS_FLAGS) begin
				rdata_next = {en_reg, flag_q};
			end else if (SFR_ADDR == `MFC_OFS_CIPHER) begin
				rdata_next = {`MFC_CIPHER_PAD_W'(0), done_reg, op_reg, mode_reg, start_reg};
			end else begin
				rdata_next = '0;
			end
		end
	end

	// Register all control state.
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			en_reg       <= `MFC_NUM_FLAGS'(`MFC_FLAGS_RST >> `MFC_EN_LSB);
			start_reg    <= `MFC_START_RST;
			mode_reg     <= `MFC_MODE_RST;
			op_reg       <= `MFC_OP_RST;
			done_reg     <= `MFC_DONE_RST;
			state_reg    <= ST_IDLE;
			run_op_reg   <= `MFC_OP_RST;
			run_enc_reg  <= `MFC_MODE_RST;
			left_reg     <= '0;
			addr_reg     <= '0;
			req_reg      <= 1'b0;
			seed_reg     <= 1'b0;
			store_reg    <= 1'b0;
			launch_reg   <= 1'b0;
			from_go_reg  <= 1'b0;
			flush_reg    <= 1'b0;
			irq_reg      <= 1'b0;
			wb_reg       <= 1'b0;
			rdata_reg    <= '0;
			crc_seed_reg <= `MFC_CRC_SEED;
		end else begin
			en_reg       <= en_next;
			start_reg    <= start_next;
			mode_reg     <= mode_next;
			op_reg       <= op_next;
			done_reg     <= done_next;
			state_reg    <= state_next;
			run_op_reg   <= run_op_next;
			run_enc_reg  <= run_enc_next;
			left_reg     <= left_next;
			addr_reg     <= addr_next;
			req_reg      <= req_next;
			seed_reg     <= seed_next;
			store_reg    <= store_next;
			launch_reg   <= launch_next;
			from_go_reg  <= from_go_next;
			flush_reg    <= flush_next;
			irq_reg      <= irq_next;
			wb_reg       <= wb_next;
			rdata_reg    <= rdata_next;
			crc_seed_reg <= `MFC_CRC_SEED;
		end
	end

	// Outputs straight from flip-flops.
	assign SFR_RDATA         = rdata_reg;
	assign IRQ               = irq_reg;
	assign TX_LAUNCH         = launch_reg;
	assign DECODER_FLUSH     = flush_reg;
	assign ENGINE_OP         = run_op_reg;
	assign ENGINE_ENCRYPT    = run_enc_reg;
	assign ENGINE_BLOCK_REQ  = req_reg;
	assign ENGINE_WRITE_BACK = wb_reg;
	assign ENGINE_BLOCK_ADDR = addr_reg;
	assign CRC_SEED_LOAD     = seed_reg;
	assign CRC_SEED          = crc_seed_reg;
	assign CRC_STORE         = store_reg;
	assign CIPHER_DONE       = done_reg;
endmodule : mfc_top
`default_nettype wire

// [test/mfc_top_asserts.sv]
// Concurrent checks on the ports of the modem event and cipher control block.
`timescale 1ns/1ns
`default_nettype none
module mfc_top_asserts #(
	parameter int ADDR_W = 16,
	parameter int CNT_W  = 16
) (
	input wire logic              CORE_CLK,
	input wire logic              SRST,
	input wire logic              OUTPUT_FRAME_GO,
	input wire logic              RETRANSMIT_GO,
	input wire logic              ACKNOWLEDGE_GO,
	input wire logic              NEW_FRAME_INCOMING,
	input wire logic              DECODER_HOLDS_DATA,
	input wire logic              TX_LAUNCH,
	input wire logic              DECODER_FLUSH,
	input wire mfc_pkg::mfc_op_t  ENGINE_OP,
	input wire logic              ENGINE_BLOCK_REQ,
	input wire logic              ENGINE_WRITE_BACK,
	input wire logic [ADDR_W-1:0] ENGINE_BLOCK_ADDR,
	input wire logic              CRC_SEED_LOAD,
	input wire logic [31:0]       CRC_SEED,
	input wire logic              CRC_STORE,
	input wire logic              CIPHER_DONE
);
	import mfc_pkg::*;
	logic go_any;	// Any of the three transmit triggers.
	logic ovf_cause;	// A new frame arrives while the decoder still holds one.
	assign go_any = OUTPUT_FRAME_GO | RETRANSMIT_GO | ACKNOWLEDGE_GO;
	assign ovf_cause = NEW_FRAME_INCOMING & DECODER_HOLDS_DATA;
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (SRST);
	// The CRC result leaves as two words, then the engine reports idle.
	sequence s_crc_pair;
		CRC_STORE[*2] ##1 (!CRC_STORE && CIPHER_DONE);
	endsequence
	a_go_launches_tx: assert property (go_any |=> TX_LAUNCH)
		else $error("transmit trigger did not launch");
	a_flush_has_cause: assert property (DECODER_FLUSH |-> $past(ovf_cause))
		else $error("decoder flush without overflow");
	a_seed_at_launch: assert property (CRC_SEED_LOAD |-> CRC_SEED == 32'hffffffff && !CIPHER_DONE)
		else $error("wrong seed at launch");
	a_crc_two_words: assert property ($rose(CRC_STORE) |-> s_crc_pair)
		else $error("CRC store not two cycles before done");
	a_crc_mode_only: assert property (CRC_STORE |-> ENGINE_OP[0])
		else $error("CRC stored without CRC mode");
	a_wb_cipher_only: assert property (ENGINE_WRITE_BACK |-> ENGINE_OP[1] && !CIPHER_DONE)
		else $error("write back outside cipher run");
	a_crc_addr_step: assert property (CRC_STORE && $past(CRC_STORE) |->
		ENGINE_BLOCK_ADDR == $past(ENGINE_BLOCK_ADDR) + 1'b1)
		else $error("CRC high word not at next address");
	a_req_while_busy: assert property (ENGINE_BLOCK_REQ |-> !CIPHER_DONE ##1 !ENGINE_BLOCK_REQ)
		else $error("block request while idle or too long");
endmodule : mfc_top_asserts
bind mfc_top mfc_top_asserts #(.ADDR_W(ADDR_W), .CNT_W(CNT_W)) u_asserts (
	.CORE_CLK, .SRST, .OUTPUT_FRAME_GO, .RETRANSMIT_GO, .ACKNOWLEDGE_GO,
	.NEW_FRAME_INCOMING, .DECODER_HOLDS_DATA, .TX_LAUNCH, .DECODER_FLUSH, .ENGINE_OP,
	.ENGINE_BLOCK_REQ, .ENGINE_WRITE_BACK, .ENGINE_BLOCK_ADDR, .CRC_SEED_LOAD,
	.CRC_SEED, .CRC_STORE, .CIPHER_DONE
);
`default_nettype wire

// [test/mfc_engine_model.sv]
// Behavioural cipher engine that answers each block request after a delay.
`timescale 1ns/1ns
`default_nettype none
module mfc_engine_model (
	input  wire logic CORE_CLK,
	input  wire logic SRST,
	input  wire logic req,
	input  wire logic slow,
	output logic      blk_done
);
	int wait_cnt = 0;	// Cycles left before the current block is finished.
	// One completion pulse per whole 64-bit block; a slow engine stalls longer.
	always @(posedge CORE_CLK) begin
		blk_done <= 1'b0;
		if (SRST) begin
			wait_cnt <= 0;
		end else if (req) begin
			wait_cnt <= slow ? 6 : 1;
		end else if (wait_cnt == 1) begin
			wait_cnt <= 0;
			blk_done <= 1'b1;
		end else if (wait_cnt > 1) begin
			wait_cnt <= wait_cnt - 1;
		end
	end
endmodule : mfc_engine_model
`default_nettype wire

// [test/mfc_top_tb.sv]
// Self-checking bench for the modem event flags and cipher control block.
`timescale 1ns/1ns
`default_nettype none
module mfc_top_tb;
	import mfc_pkg::*;
	logic        CORE_CLK = 1'b0;	// Core clock, 100 ns period.
	logic        SRST = 1'b1;	// Reset, high at start.
	logic [4:0]  SFR_ADDR = 5'h00;
	logic        SFR_WR_EN = 1'b0;
	logic        SFR_RD_EN = 1'b0;
	logic [15:0] SFR_WDATA = 16'h0000;
	logic [5:0]  ev = 6'h00;	// Frame path events in flag order, cipher and overflow excluded.
	logic [2:0]  go = 3'h0;	// Output start, retransmit and acknowledge triggers.
	logic        NEW_FRAME_INCOMING = 1'b0;
	logic        DECODER_HOLDS_DATA = 1'b0;
	logic [15:0] CIPHER_START_ADDRESS = 16'h0000;
	logic [15:0] CIPHER_BLOCK_COUNT = 16'h0000;
	logic        slow = 1'b0;	// Engine model answers slowly when set.
	wire logic   PHY_TX_LAST_BIT = ev[0];
	wire logic   MGR_TX_LAST_BYTE = ev[1];
	wire logic   PHY_RX_LAST_BIT = ev[2];
	wire logic   MGR_RX_LAST_BYTE = ev[3];
	wire logic   CARRIER_DETECT = ev[4];
	wire logic   FRAME_VALID = ev[5];
	wire logic   OUTPUT_FRAME_GO = go[0];
	wire logic   RETRANSMIT_GO = go[1];
	wire logic   ACKNOWLEDGE_GO = go[2];
	wire logic   ENGINE_BLOCK_DONE;
	logic [15:0] SFR_RDATA, ENGINE_BLOCK_ADDR;
	logic        IRQ, TX_LAUNCH, DECODER_FLUSH, ENGINE_ENCRYPT, ENGINE_BLOCK_REQ;
	logic        ENGINE_WRITE_BACK, CRC_SEED_LOAD, CRC_STORE, CIPHER_DONE;
	logic [31:0] CRC_SEED;
	mfc_op_t     ENGINE_OP;
	int          err_count = 0;
	int          n_checks = 0;
	int          cyc = 0;	// Cycles run, for the hang limit.
	int          n_req = 0, n_store = 0, n_wb = 0, n_flush = 0, n_launch = 0;
	logic [15:0] first_addr, last_addr;	// First block address and last CRC word address.

	mfc_top dut (.*);
	mfc_engine_model u_eng (
		.CORE_CLK (CORE_CLK),
		.SRST     (SRST),
		.req      (ENGINE_BLOCK_REQ),
		.slow     (slow),
		.blk_done (ENGINE_BLOCK_DONE)
	);

	// Free-running clock.
	initial begin
		forever #50 CORE_CLK = ~CORE_CLK;
	end

	// Tally design pulses each cycle and cut a hang short.
	always @(posedge CORE_CLK) begin
		cyc <= cyc + 1;
		if (ENGINE_BLOCK_REQ && n_req == 0) first_addr <= ENGINE_BLOCK_ADDR;
		if (CRC_STORE) last_addr <= ENGINE_BLOCK_ADDR;
		n_req <= n_req + int'(ENGINE_BLOCK_REQ);
		n_store <= n_store + int'(CRC_STORE);
		n_wb <= n_wb + int'(ENGINE_WRITE_BACK);
		n_flush <= n_flush + int'(DECODER_FLUSH);
		n_launch <= n_launch + int'(TX_LAUNCH);
		if (cyc == 20000) begin
			err_count++;
			finish_test();
		end
	end

	task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic cycles(input int n);
		repeat (n) @(negedge CORE_CLK);
	endtask : cycles

	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(negedge CORE_CLK);
		SFR_ADDR = a;
		SFR_WDATA = d;
		SFR_WR_EN = 1'b1;
		@(negedge CORE_CLK);
		SFR_WR_EN = 1'b0;
	endtask : wr

	// Reads one register and compares it with the expected word.
	task automatic rdc(input logic [4:0] a, input logic [15:0] exp, input string name);
		@(negedge CORE_CLK);
		SFR_ADDR = a;
		SFR_RD_EN = 1'b1;
		@(negedge CORE_CLK);
		SFR_RD_EN = 1'b0;
		chk(name, SFR_RDATA, exp);
	endtask : rdc

	task automatic pulse(input int k, input logic is_go);
		@(negedge CORE_CLK);
		if (is_go) go[k] = 1'b1;
		else ev[k] = 1'b1;
		@(negedge CORE_CLK);
		go = 3'h0;
		ev = 6'h00;
	endtask : pulse

	task automatic t_registers();
		rdc(5'h00, 16'h0000, "flags after reset");
		rdc(5'h01, 16'h001c, "cipher after reset");
		rdc(5'h09, 16'h0000, "unmapped read");
		wr(5'h00, 16'hffff);
		rdc(5'h00, 16'hffff, "flags all ones");
		chk("irq all enabled", IRQ, 32'h1);
		wr(5'h00, 16'h0000);
		rdc(5'h00, 16'h0000, "flags cleared");
		chk("irq cleared", IRQ, 32'h0);
		wr(5'h01, 16'hffe2);
		rdc(5'h01, 16'h0012, "cipher fixed bits");
		wr(5'h01, 16'h000c);
		rdc(5'h01, 16'h001c, "direction cleared");
	endtask : t_registers

	// Each event sets its own flag; the enable above it gates the interrupt.
	task automatic t_flag_events();
		int          fi[6] = '{0, 1, 2, 3, 5, 6};
		logic [15:0] fb;
		for (int i = 0; i < 6; i++) begin
			fb = 16'h0001 << fi[i];
			pulse(0, 1'b1);
			pulse(i, 1'b0);
			rdc(5'h00, fb, "flag set by event");
			chk("irq masked", IRQ, 32'h0);
			wr(5'h00, fb | (fb << 8));
			cycles(2);
			chk("irq enabled", IRQ, 32'h1);
			wr(5'h00, 16'h0000);
			rdc(5'h00, 16'h0000, "flag cleared");
			chk("irq dropped", IRQ, 32'h0);
		end
	endtask : t_flag_events

	// Every trigger launches; only output start earns the manager flag.
	task automatic t_transmit();
		for (int k = 0; k < 3; k++) begin
			n_launch = 0;
			pulse(k, 1'b1);
			cycles(1);
			chk("launch per trigger", n_launch, 32'h1);
			pulse(1, 1'b0);
			pulse(0, 1'b0);
			rdc(5'h00, (k == 0) ? 16'h0003 : 16'h0001, "tx flags per trigger");
			wr(5'h00, 16'h0000);
		end
	endtask : t_transmit

	// A carrier in the cycle of a clearing write keeps its flag.
	task automatic t_set_wins();
		@(negedge CORE_CLK);
		ev[4] = 1'b1;
		SFR_ADDR = 5'h00;
		SFR_WDATA = 16'h0000;
		SFR_WR_EN = 1'b1;
		@(negedge CORE_CLK);
		ev[4] = 1'b0;
		SFR_WR_EN = 1'b0;
		rdc(5'h00, 16'h0020, "set beats clear");
		wr(5'h00, 16'h0000);
	endtask : t_set_wins

	task automatic t_overflow();
		DECODER_HOLDS_DATA = 1'b1;
		for (int en = 1; en >= 0; en--) begin
			wr(5'h00, en ? 16'h8000 : 16'h0000);
			n_flush = 0;
			@(negedge CORE_CLK);
			NEW_FRAME_INCOMING = 1'b1;
			@(negedge CORE_CLK);
			NEW_FRAME_INCOMING = 1'b0;
			cycles(2);
			chk("flush count", n_flush, en);
			rdc(5'h00, en ? 16'h8080 : 16'h0000, "overflow flag");
			chk("overflow irq", IRQ, en);
		end
		DECODER_HOLDS_DATA = 1'b0;
	endtask : t_overflow

	// Runs every operation code with assorted block counts and engine speeds.
	task automatic t_cipher();
		logic [1:0]  ops[5] = '{2'b00, 2'b01, 2'b10, 2'b11, 2'b11};
		logic [15:0] cnts[5] = '{16'h0002, 16'h0002, 16'h0003, 16'h0001, 16'h0000};
		int          t;
		for (int i = 0; i < 5; i++) begin
			slow = i[0];
			CIPHER_START_ADDRESS = 16'h0100 + 16'(i * 64);
			CIPHER_BLOCK_COUNT = cnts[i];
			n_req = 0;
			n_store = 0;
			n_wb = 0;
			wr(5'h01, {12'h000, ops[i], i[0], 1'b1});
			t = 0;
			while (CIPHER_DONE !== 1'b0 && t < 10 && ops[i] != 2'b00) begin
				@(negedge CORE_CLK);
				t++;
			end
			if (ops[i] == 2'b00) begin
				cycles(3);
				chk("op off stays idle", {CIPHER_DONE, n_req[7:0]}, 32'h100);
				rdc(5'h01, 16'h0010, "op off start cleared");
			end else begin
				chk("op latched", ENGINE_OP, ops[i]);
				chk("direction latched", ENGINE_ENCRYPT, i[0]);
				if (cnts[i] != 0) rdc(5'h01, {11'h000, 1'b0, ops[i], i[0], 1'b0}, "start self clears");
				while (CIPHER_DONE !== 1'b1 && t < 200) begin
					@(negedge CORE_CLK);
					t++;
				end
				chk("blocks requested", n_req, cnts[i]);
				chk("crc store cycles", n_store, ops[i][0] ? 2 : 0);
				chk("write back seen", n_wb != 0, ops[i][1]);
				if (cnts[i] != 0) chk("first block addr", first_addr, CIPHER_START_ADDRESS);
				if (ops[i][0]) chk("crc after data", last_addr, CIPHER_START_ADDRESS + (cnts[i] << 2) + 1);
				rdc(5'h00, 16'h0010, "cipher done flag");
				wr(5'h00, 16'h0000);
			end
		end
	endtask : t_cipher

	task automatic finish_test();
		if (err_count == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : finish_test

	// Main sequence: reset for three cycles, then each scenario in turn.
	initial begin
		repeat (3) @(negedge CORE_CLK);
		SRST = 1'b0;
		t_registers();
		t_flag_events();
		t_transmit();
		t_set_wins();
		t_overflow();
		t_cipher();
		finish_test();
	end
endmodule : mfc_top_tb
`default_nettype wire
